// >>> logic/sxd_cfg.svh
// Constants for the stretched external data access block
`ifndef SXD_CFG_SVH
`define SXD_CFG_SVH
`define SXD_CTRL_ADDR      8'h8e
`define SXD_STRETCH_LSB    0
`define SXD_STRETCH_MSB    2
`define SXD_T0_RATE_BIT    3
`define SXD_T1_RATE_BIT    4
`define SXD_T2_RATE_BIT    5
`define SXD_STRETCH_RST    3'h1
`define SXD_RATE_RST       3'h0
`define SXD_CLKS_PER_MC    4
`define SXD_BASE_MC        2
`define SXD_STROBE_ZERO    2
`define SXD_STROBE_STEP    4
`endif

// >>> logic/sxd_pkg.sv
// Types for the stretched external data access block
package sxd_pkg;
    typedef enum logic [1:0] {
        SXD_IDLE,
        SXD_ADDR,
        SXD_DATA
    } sxd_state_t;

    // Request from the core for one bus access
    typedef struct packed {
        logic        is_data;
        logic        is_write;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } sxd_req_t;

    // Pin group of the external bus
    typedef struct packed {
        logic [7:0] low_addr_data_port;
        logic       low_addr_data_oe_n;
        logic [7:0] high_addr_port;
        logic       ale;
        logic       rd_n;
        logic       wr_n;
        logic       psen_n;
    } sxd_pins_t;
endpackage

// >>> logic/sxd_mc_timer.sv
// Machine-cycle enable divider
`timescale 1ns/10ps
`include "sxd_cfg.svh"
module sxd_mc_timer #(
    parameter int CLKS = `SXD_CLKS_PER_MC
) (
    input  wire logic       mclk,
    input  wire logic       rstn,
    output logic            mc_tick,
    output logic [1:0]      phase
);
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;

    // Free-running phase counter, wraps every machine cycle
    always_comb begin
        cnt_nxt = (cnt_r == 2'(CLKS - 1)) ? 2'h0 : cnt_r + 2'h1;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cnt_r <= 2'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign mc_tick = (cnt_r == 2'(CLKS - 1));
    assign phase   = cnt_r;

    mc_period_a: assert property (@(posedge mclk) disable iff (!rstn)
        mc_tick |=> !mc_tick [*3] ##1 mc_tick) else $error("machine cycle not 4 clocks");
endmodule

// >>> logic/sxd_access.sv
// External bus sequencer with stretchable data moves
`timescale 1ns/10ps
`include "sxd_cfg.svh"
// How it works
// - Stretch taken from control register bits 2..0
// - Data move lasts two plus stretch cycles
// - Reset stretch value is one
// - Every machine cycle is four clocks
// - Strobe 2 clocks, else 4 per step
// - Nonzero stretch widens strobe and timing
// - Program fetches ignore the stretch value
// - New stretch applies to following moves
// - Multiplexed low port plus high address port
// - All fetches go over the external bus
// - Address while latch high, then data bus
// - Bits 5..3 pick timer rates, reset zero
// - Data move address taken from req.addr
module sxd_access (
    input  wire logic              mclk,
    input  wire logic              rstn,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    output logic [7:0]             reg_rdata,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire sxd_pkg::sxd_req_t req,
    output logic                   done,
    output logic [7:0]             rdata,
    input  wire logic [7:0]        port_in,
    output sxd_pkg::sxd_pins_t     pins,
    output logic [2:0]             timer_rate_sel
);
    logic                 mc_tick;
    logic [1:0]           phase;
    sxd_pkg::sxd_state_t  st_r, st_nxt;
    logic [7:0]           ctrl_r, ctrl_nxt;
    logic [2:0]           strch_r, strch_nxt;
    logic [3:0]           mc_left_r, mc_left_nxt;
    logic [5:0]           strb_r, strb_nxt;
    logic [5:0]           clk_left;
    sxd_pkg::sxd_req_t    cur_r, cur_nxt;
    logic [7:0]           rdata_r, rdata_nxt;
    logic                 done_r, done_nxt;
    sxd_pkg::sxd_pins_t   pins_r, pins_nxt;

    // Strobe width in clocks for a stretch value
    function automatic logic [5:0] strobe_clks(input logic [2:0] s);
        strobe_clks = (s == 3'h0) ? 6'(`SXD_STROBE_ZERO)
                                  : 6'(`SXD_STROBE_STEP) * {3'h0, s};
    endfunction

    sxd_mc_timer u_mc (
        .mclk    (mclk),
        .rstn    (rstn),
        .mc_tick (mc_tick),
        .phase   (phase)
    );

    // Register port: control register write and readback
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (reg_wr && reg_addr == `SXD_CTRL_ADDR) begin
            ctrl_nxt = {2'h0, reg_wdata[5:0]};
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ctrl_r <= {2'h0, `SXD_RATE_RST, `SXD_STRETCH_RST};
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Unmapped addresses read zero
    assign reg_rdata = (reg_rd && reg_addr == `SXD_CTRL_ADDR) ? ctrl_r : 8'h00;
    assign timer_rate_sel = {ctrl_r[`SXD_T2_RATE_BIT], ctrl_r[`SXD_T1_RATE_BIT],
                             ctrl_r[`SXD_T0_RATE_BIT]};
    assign req_ready = (st_r == sxd_pkg::SXD_IDLE) && mc_tick;

    // Clocks left in the move, current one included; only meaningful in the data phase
    assign clk_left = {mc_left_r, 2'h0} - {4'h0, phase};

    // Access sequencer: address phase one cycle, then data phase
    always_comb begin
        st_nxt      = st_r;
        strch_nxt   = strch_r;
        mc_left_nxt = mc_left_r;
        strb_nxt    = strb_r;
        cur_nxt     = cur_r;
        rdata_nxt   = rdata_r;
        done_nxt    = 1'b0;
        pins_nxt    = pins_r;
        case (st_r)
            sxd_pkg::SXD_IDLE: begin
                pins_nxt.ale    = 1'b0;
                pins_nxt.rd_n   = 1'b1;
                pins_nxt.wr_n   = 1'b1;
                pins_nxt.psen_n = 1'b1;
                pins_nxt.low_addr_data_oe_n = 1'b1;
                if (req_valid && req_ready) begin
                    cur_nxt = req;
                    // Stretch latched here so a write mid-move cannot disturb it
                    strch_nxt = req.is_data ? ctrl_r[`SXD_STRETCH_MSB:`SXD_STRETCH_LSB]
                                            : 3'h0;
                    mc_left_nxt = req.is_data
                        ? 4'(`SXD_BASE_MC) + {1'b0, ctrl_r[2:0]} - 4'h1
                        : 4'h1;
                    // Fetch gets one data-phase cycle and a short strobe, whatever the stretch
                    strb_nxt = req.is_data ? strobe_clks(ctrl_r[2:0]) : 6'(`SXD_STROBE_ZERO);
                    pins_nxt.ale = 1'b1;
                    pins_nxt.low_addr_data_port = req.addr[7:0];
                    pins_nxt.high_addr_port     = req.addr[15:8];
                    pins_nxt.low_addr_data_oe_n = 1'b0;
                    st_nxt = sxd_pkg::SXD_ADDR;
                end
            end
            sxd_pkg::SXD_ADDR: begin
                if (phase == 2'h1) begin
                    pins_nxt.ale = 1'b0;
                end
                if (mc_tick) begin
                    // Strobe sits at the end of the move so wait states widen it
                    pins_nxt.low_addr_data_oe_n = !(cur_r.is_data && cur_r.is_write);
                    pins_nxt.low_addr_data_port = cur_r.wdata;
                    st_nxt = sxd_pkg::SXD_DATA;
                end
            end
            sxd_pkg::SXD_DATA: begin
                // Strobe ends one clock before the move, so write data outlives it
                if (strb_r != 6'h0 && clk_left >= 6'h3 &&
                    clk_left <= strb_r + 6'h2) begin
                    pins_nxt.rd_n   = !(cur_r.is_data && !cur_r.is_write);
                    pins_nxt.wr_n   = !(cur_r.is_data && cur_r.is_write);
                    pins_nxt.psen_n = cur_r.is_data;
                end else begin
                    pins_nxt.rd_n   = 1'b1;
                    pins_nxt.wr_n   = 1'b1;
                    pins_nxt.psen_n = 1'b1;
                end
                if (!pins_r.rd_n || !pins_r.psen_n) begin
                    rdata_nxt = port_in;
                end
                if (mc_tick) begin
                    if (mc_left_r <= 4'h1) begin
                        done_nxt = 1'b1;
                        pins_nxt.low_addr_data_oe_n = 1'b1;
                        st_nxt = sxd_pkg::SXD_IDLE;
                    end else begin
                        mc_left_nxt = mc_left_r - 4'h1;
                    end
                end
            end
            default: begin
                st_nxt = sxd_pkg::SXD_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st_r      <= sxd_pkg::SXD_IDLE;
            strch_r   <= `SXD_STRETCH_RST;
            mc_left_r <= 4'h0;
            strb_r    <= 6'h0;
            cur_r     <= '0;
            rdata_r   <= 8'h00;
            done_r    <= 1'b0;
            pins_r    <= '{low_addr_data_port: 8'hff, low_addr_data_oe_n: 1'b1,
                           high_addr_port: 8'hff, ale: 1'b0, rd_n: 1'b1,
                           wr_n: 1'b1, psen_n: 1'b1};
        end else begin
            st_r      <= st_nxt;
            strch_r   <= strch_nxt;
            mc_left_r <= mc_left_nxt;
            strb_r    <= strb_nxt;
            cur_r     <= cur_nxt;
            rdata_r   <= rdata_nxt;
            done_r    <= done_nxt;
            pins_r    <= pins_nxt;
        end
    end

    assign pins  = pins_r;
    assign rdata = rdata_r;
    assign done  = done_r;

    // Checks on the visible bus behaviour
    reset_stretch_a: assert property (@(posedge mclk) $rose(rstn) |-> ctrl_r[2:0] == 3'h1)
        else $error("stretch not one after reset");
    ctrl_read_a: assert property (@(posedge mclk) disable iff (!rstn)
        (reg_rd && reg_addr == `SXD_CTRL_ADDR) |-> reg_rdata[2:0] == ctrl_r[2:0])
        else $error("stretch readback wrong");
    ale_addr_a: assert property (@(posedge mclk) disable iff (!rstn)
        pins_r.ale |-> pins_r.low_addr_data_port == cur_r.addr[7:0])
        else $error("low port not address during latch");
    zero_strobe_a: assert property (@(posedge mclk) disable iff (!rstn)
        ($fell(pins_r.rd_n) && strch_r == 3'h0) |-> !pins_r.rd_n [*2] ##1 pins_r.rd_n)
        else $error("stretch zero strobe not 2 clocks");
    one_strobe_a: assert property (@(posedge mclk) disable iff (!rstn)
        ($fell(pins_r.wr_n) && strch_r == 3'h1) |-> !pins_r.wr_n [*4] ##1 pins_r.wr_n)
        else $error("stretch one strobe not 4 clocks");
    // Done is registered, so it shows one clock after the final clock of the access
    fetch_len_a: assert property (@(posedge mclk) disable iff (!rstn)
        (req_valid && req_ready && !req.is_data) |=> ##8 done_r)
        else $error("fetch not two machine cycles");
    move_len_a: assert property (@(posedge mclk) disable iff (!rstn)
        (req_valid && req_ready && req.is_data && ctrl_r[2:0] == 3'h0) |=> ##8 done_r)
        else $error("fast data move not 8 clocks");
    fetch_no_rdwr_a: assert property (@(posedge mclk) disable iff (!rstn)
        !cur_r.is_data |-> pins_r.rd_n && pins_r.wr_n)
        else $error("fetch drove data strobe");
    ctrl_write_a: assert property (@(posedge mclk) disable iff (!rstn)
        (reg_wr && reg_addr == `SXD_CTRL_ADDR) |=> ctrl_r[5:0] == $past(reg_wdata[5:0]))
        else $error("control write not taken");
    // A write strobe with the port released would latch a floating bus
    wr_data_a: assert property (@(posedge mclk) disable iff (!rstn)
        !pins_r.wr_n |-> !pins_r.low_addr_data_oe_n)
        else $error("write strobe without data driven");
endmodule

// >>> verification/sxd_ext_ram.sv
// External data RAM model seen through the multiplexed bus pins
`timescale 1ns/10ps
module sxd_ext_ram (
    input  wire logic               mclk,
    input  wire sxd_pkg::sxd_pins_t pins,
    output logic [7:0]              port_in
);
    logic [7:0]  mem [0:65535];
    logic [15:0] addr_r;
    logic [7:0]  last_r = 8'h00;
    logic        rd_act;

    // Latch the address while the latch strobe is high; store data under write strobe
    always @(posedge mclk) begin
        if (pins.ale) addr_r <= {pins.high_addr_port, pins.low_addr_data_port};
        if (!pins.wr_n && !pins.low_addr_data_oe_n) mem[addr_r] <= pins.low_addr_data_port;
        if (rd_act) last_r <= port_in;
    end

    // Released bus shows the inverse of the last value, never a stale copy
    assign rd_act  = !pins.rd_n || !pins.psen_n;
    assign port_in = rd_act ? mem[addr_r] : ~last_r;
endmodule

// >>> verification/stretched_external_data_access_test.sv
// Self-checking bench for the stretched external data access sequencer
`timescale 1ns/10ps
`include "sxd_cfg.svh"
module stretched_external_data_access_test;
    logic               mclk = 1'b0;
    logic               rstn = 1'b0;
    logic               reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0;
    logic [7:0]         reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rdata, port_in;
    logic               req_ready, done;
    logic [2:0]         timer_rate_sel;
    sxd_pkg::sxd_req_t  req = '0;
    sxd_pkg::sxd_pins_t pins;
    int                 errors = 0, tests_run = 0, cyc = 0, ln, sb;

    sxd_access uut (.mclk(mclk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .req_valid(req_valid), .req_ready(req_ready), .req(req), .done(done), .rdata(rdata),
        .port_in(port_in), .pins(pins), .timer_rate_sel(timer_rate_sel));
    sxd_ext_ram ram (.mclk(mclk), .pins(pins), .port_in(port_in));

    always #2.5 mclk = ~mclk;
    // Hang guard, well above the longest run
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            finish_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge mclk);
        #1 reg_wr = 1'b0;
        // Let an edge pass so back-to-back calls never retoggle the strobe
        @(posedge mclk);
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        // Read held across an edge so the readback check sees it
        @(posedge mclk);
        #1 chk("reg_rdata", {24'h0, exp}, {24'h0, reg_rdata});
        reg_rd = 1'b0;
        @(posedge mclk);
        #1;
    endtask

    // One access: hold the request until taken, count clocks to done and strobe clocks
    task automatic access(input logic dat, input logic wr, input logic [15:0] a,
                          input logic [7:0] d, output int len, output int strobe);
        int n;
        n = 0;
        req_valid = 1'b1;
        req = '{dat, wr, a, d};
        while (req_ready !== 1'b1 && n < 50) begin
            @(posedge mclk);
            #1 n++;
        end
        @(posedge mclk);
        #1 req_valid = 1'b0;
        len = 0;
        strobe = 0;
        while (done !== 1'b1 && len < 60) begin
            if (pins.rd_n === 1'b0 || pins.wr_n === 1'b0 || pins.psen_n === 1'b0) strobe++;
            @(posedge mclk);
            #1 len++;
        end
    endtask

    task automatic test_reset;
        rd_chk(`SXD_CTRL_ADDR, 8'h01);
        chk("timer_rate_sel", 32'h0, {29'h0, timer_rate_sel});
        access(1'b1, 1'b1, 16'h0100, 8'h3c, ln, sb);
        chk("default move clocks", 32'd12, ln);
        chk("default strobe clocks", 32'd4, sb);
        access(1'b1, 1'b0, 16'h0100, 8'h00, ln, sb);
        chk("default move clocks", 32'd12, ln);
        chk("rdata", 32'h3c, {24'h0, rdata});
        $display("test_reset done");
    endtask

    task automatic test_regs;
        wr_reg(`SXD_CTRL_ADDR, 8'hff);
        rd_chk(`SXD_CTRL_ADDR, 8'h3f);
        chk("timer_rate_sel", 32'h7, {29'h0, timer_rate_sel});
        wr_reg(8'h8f, 8'h00);
        rd_chk(`SXD_CTRL_ADDR, 8'h3f);
        rd_chk(8'h8f, 8'h00);
        $display("test_regs done");
    endtask

    // Every stretch code: move length and strobe width; software picks 0 and 7 too
    task automatic test_stretch;
        for (int s = 0; s < 8; s++) begin
            wr_reg(`SXD_CTRL_ADDR, s[7:0]);
            access(1'b1, 1'b0, 16'h0000, 8'h00, ln, sb);
            chk("move clocks", (2 + s) * 4, ln);
            chk("strobe clocks", (s == 0) ? 2 : 4 * s, sb);
            access(1'b0, 1'b0, 16'h0040, 8'h00, ln, sb);
            chk("fetch clocks", 32'd8, ln);
            chk("fetch strobe clocks", `SXD_STROBE_ZERO, sb);
        end
        $display("test_stretch done");
    endtask

    task automatic test_data;
        wr_reg(`SXD_CTRL_ADDR, 8'h00);
        access(1'b1, 1'b1, 16'h12c4, 8'ha5, ln, sb);
        access(1'b1, 1'b1, 16'h13c4, 8'h5a, ln, sb);
        wr_reg(`SXD_CTRL_ADDR, 8'h07);
        access(1'b1, 1'b0, 16'h12c4, 8'h00, ln, sb);
        chk("rdata", 32'ha5, {24'h0, rdata});
        access(1'b1, 1'b0, 16'h13c4, 8'h00, ln, sb);
        chk("rdata", 32'h5a, {24'h0, rdata});
        $display("test_data done");
    endtask

    // Rewrite during a move: current move keeps its length, next one uses the new value
    task automatic test_rewrite;
        wr_reg(`SXD_CTRL_ADDR, 8'h02);
        fork
            access(1'b1, 1'b0, 16'h12c4, 8'h00, ln, sb);
            begin
                repeat (8) @(posedge mclk);
                #1 wr_reg(`SXD_CTRL_ADDR, 8'h00);
            end
        join
        chk("move clocks", 32'd16, ln);
        access(1'b1, 1'b0, 16'h12c4, 8'h00, ln, sb);
        chk("move clocks", 32'd8, ln);
        $display("test_rewrite done");
    endtask

    // Reset in mid-run: register back to defaults, memory contents untouched
    task automatic test_rereset;
        wr_reg(`SXD_CTRL_ADDR, 8'h3f);
        rstn = 1'b0;
        repeat (4) @(posedge mclk);
        #1 rstn = 1'b1;
        rd_chk(`SXD_CTRL_ADDR, 8'h01);
        chk("timer_rate_sel", 32'h0, {29'h0, timer_rate_sel});
        access(1'b1, 1'b0, 16'h12c4, 8'h00, ln, sb);
        chk("default move clocks", 32'd12, ln);
        chk("rdata", 32'ha5, {24'h0, rdata});
        $display("test_rereset done");
    endtask

    task automatic finish_test;
        $display("Comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        #1 rstn = 1'b1;
        test_reset();
        test_regs();
        test_stretch();
        test_data();
        test_rewrite();
        test_rereset();
        finish_test();
    end
endmodule
